// ==== logic/fpsc_defines.vh ====
`ifndef FPSC_DEFINES_VH
`define FPSC_DEFINES_VH
// ==========================================================
// Command codes and addresses
`define FPSC_ADDR_UNLOCK1 12'h555
`define FPSC_ADDR_UNLOCK2 12'h2AA
`define FPSC_D_UNLOCK1 8'hAA
`define FPSC_D_UNLOCK2 8'h55
`define FPSC_D_STATUS 8'h70
`define FPSC_D_WBUF 8'h25
`define FPSC_D_CONFIRM 8'h29
`define FPSC_D_SUSP_LEG 8'hB0
`define FPSC_D_SUSP_ENH 8'h51
`define FPSC_D_RES_LEG 8'h30
`define FPSC_D_RES_ENH 8'h50
// ==========================================================
// Limits and timing
`define FPSC_MAX_WORDS 9'h100
`define FPSC_WR_CYCLES 4'h3
// Hold latency of 20000 ns in 25 ns core clocks, sized for the counter
`define FPSC_LAT_CYC 16'h0320
`endif

// ==== logic/fpsc_host.v ====
// Contract
// - In erase hold, load count over 256 or new sector aborts to programming.
// - Up to 256 words per sector, then 29h at sector confirms programming.
// - B0h or 51h anywhere during busy program requests program hold.
// - 30h or 50h anywhere while paused resumes programming in erase hold.
// - While paused, 70h@555h reads status once; AA/55 unlock still allows resume.
`include "fpsc_defines.vh"
module fpsc_host (
  // Clock and reset
  input wire CORE_CLK,
  input wire ARST_N,
  // Command port
  input wire CMD_VALID,
  input wire [2:0] CMD_OP,
  input wire [23:0] CMD_ADDR,
  input wire [15:0] CMD_DATA,
  input wire [8:0] CMD_COUNT,
  input wire CMD_LAST,
  input wire CMD_IN_ERASE_HOLD,
  output reg CMD_READY,
  output reg CMD_ERROR,
  output reg [15:0] STATUS,
  output reg STATUS_VALID,
  // Flash bus
  output reg [23:0] FL_A,
  output reg [15:0] FL_DQ_OUT,
  output reg FL_DQ_OE,
  input wire [15:0] FL_DQ_IN,
  output reg FL_CE_N,
  output reg FL_WE_N,
  output reg FL_OE_N
);
  // ========================================================
  // Ops: 0 word program, 1 buffer open, 2 buffer word, 3 suspend,
  // 4 resume, 5 status read, 6 unlock pair
  localparam OP_WBOPEN = 3'h1;
  localparam OP_WDATA = 3'h2;
  localparam OP_SUSP = 3'h3;
  localparam OP_RES = 3'h4;
  localparam OP_STAT = 3'h5;
  localparam OP_UNLOCK = 3'h6;
  localparam S_IDLE = 3'h0;
  localparam S_WR = 3'h1;
  localparam S_GAP = 3'h2;
  localparam S_RD = 3'h3;
  localparam S_WAIT = 3'h4;

  reg [2:0] state;
  reg [3:0] ph;
  reg [2:0] nseq;
  reg [2:0] idx;
  reg [23:0] seq_a [0:3];
  reg [15:0] seq_d [0:3];
  reg [8:0] left;
  reg [23:0] sector;
  reg loading;
  reg hold_mode;
  reg paused;
  reg [15:0] lat;
  reg do_read;
  reg do_wait;
  reg [23:0] sec_of;
  reg ok;
  integer k;

  always @* begin
    sec_of = {CMD_ADDR[23:16], 16'h0000};
    ok = 1'b1;
    case (CMD_OP)
      OP_WBOPEN: ok = (CMD_COUNT != 9'h000) &&
                      (CMD_COUNT <= `FPSC_MAX_WORDS) && !loading;
      OP_WDATA: ok = loading && (sec_of == sector) &&
                     (left != 9'h000);
      OP_SUSP: ok = !loading && !paused;
      OP_RES: ok = paused;
      OP_STAT: ok = 1'b1;
      OP_UNLOCK: ok = 1'b1;
      default: ok = !loading && !paused;
    endcase
  end

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= S_IDLE;
      ph <= 4'h0;
      nseq <= 3'h0;
      idx <= 3'h0;
      for (k = 0; k < 4; k = k + 1) begin
        seq_a[k] <= 24'h000000;
        seq_d[k] <= 16'h0000;
      end
      left <= 9'h000;
      sector <= 24'h000000;
      loading <= 1'b0;
      hold_mode <= 1'b0;
      paused <= 1'b0;
      lat <= 16'h0000;
      do_read <= 1'b0;
      do_wait <= 1'b0;
      CMD_READY <= 1'b0;
      CMD_ERROR <= 1'b0;
      STATUS <= 16'h0000;
      STATUS_VALID <= 1'b0;
      FL_A <= 24'h000000;
      FL_DQ_OUT <= 16'h0000;
      FL_DQ_OE <= 1'b0;
      FL_CE_N <= 1'b1;
      FL_WE_N <= 1'b1;
      FL_OE_N <= 1'b1;
    end else begin
      CMD_ERROR <= 1'b0;
      STATUS_VALID <= 1'b0;
      case (state)
        S_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY) begin
            CMD_READY <= 1'b0;
            idx <= 3'h0;
            do_read <= 1'b0;
            do_wait <= 1'b0;
            if (!ok) begin
              // Refused locally so the flash never sees an invalid cycle
              CMD_ERROR <= 1'b1;
              CMD_READY <= 1'b1;
            end else begin
              state <= S_WR;
              case (CMD_OP)
                OP_WBOPEN: begin
                  seq_a[0] <= {12'h000, `FPSC_ADDR_UNLOCK1};
                  seq_d[0] <= {8'h00, `FPSC_D_UNLOCK1};
                  seq_a[1] <= {12'h000, `FPSC_ADDR_UNLOCK2};
                  seq_d[1] <= {8'h00, `FPSC_D_UNLOCK2};
                  seq_a[2] <= sec_of;
                  seq_d[2] <= {8'h00, `FPSC_D_WBUF};
                  seq_a[3] <= sec_of;
                  seq_d[3] <= {7'h00, CMD_COUNT - 9'h001};
                  nseq <= 3'h4;
                  sector <= sec_of;
                  left <= CMD_COUNT;
                  loading <= 1'b1;
                  hold_mode <= CMD_IN_ERASE_HOLD;
                end
                OP_WDATA: begin
                  seq_a[0] <= CMD_ADDR;
                  seq_d[0] <= CMD_DATA;
                  nseq <= 3'h1;
                  left <= left - 9'h001;
                  if (left == 9'h001) begin
                    // Confirm at the sector once the count runs out
                    seq_a[1] <= sector;
                    seq_d[1] <= {8'h00, `FPSC_D_CONFIRM};
                    nseq <= 3'h2;
                    loading <= 1'b0;
                  end
                end
                OP_SUSP: begin
                  seq_a[0] <= CMD_ADDR;
                  seq_d[0] <= {8'h00, CMD_DATA[0] ?
                    `FPSC_D_SUSP_ENH : `FPSC_D_SUSP_LEG};
                  nseq <= 3'h1;
                  paused <= 1'b1;
                  do_wait <= 1'b1;
                  hold_mode <= CMD_IN_ERASE_HOLD;
                end
                OP_RES: begin
                  seq_a[0] <= CMD_ADDR;
                  seq_d[0] <= {8'h00, CMD_DATA[0] ?
                    `FPSC_D_RES_ENH : `FPSC_D_RES_LEG};
                  nseq <= 3'h1;
                  paused <= 1'b0;
                end
                OP_STAT: begin
                  seq_a[0] <= {12'h000, `FPSC_ADDR_UNLOCK1};
                  seq_d[0] <= {8'h00, `FPSC_D_STATUS};
                  nseq <= 3'h1;
                  do_read <= 1'b1;
                end
                OP_UNLOCK: begin
                  seq_a[0] <= {12'h000, `FPSC_ADDR_UNLOCK1};
                  seq_d[0] <= {8'h00, `FPSC_D_UNLOCK1};
                  seq_a[1] <= {12'h000, `FPSC_ADDR_UNLOCK2};
                  seq_d[1] <= {8'h00, `FPSC_D_UNLOCK2};
                  nseq <= 3'h2;
                end
                default: begin
                  seq_a[0] <= CMD_ADDR;
                  seq_d[0] <= CMD_DATA;
                  nseq <= 3'h1;
                end
              endcase
            end
          end
        end
        S_WR: begin
          // Write cycle: WE low for a fixed number of core clocks
          FL_A <= seq_a[idx[1:0]];
          FL_DQ_OUT <= seq_d[idx[1:0]];
          FL_DQ_OE <= 1'b1;
          FL_CE_N <= 1'b0;
          FL_WE_N <= 1'b0;
          ph <= ph + 4'h1;
          if (ph == `FPSC_WR_CYCLES) begin
            FL_WE_N <= 1'b1;
            ph <= 4'h0;
            state <= S_GAP;
          end
        end
        S_GAP: begin
          FL_CE_N <= 1'b1;
          FL_DQ_OE <= 1'b0;
          idx <= idx + 3'h1;
          if (idx + 3'h1 < nseq) begin
            state <= S_WR;
          end else if (do_read) begin
            state <= S_RD;
          end else if (do_wait) begin
            // Keyed on the op, so data words that look like B0h don't stall
            lat <= `FPSC_LAT_CYC;
            state <= S_WAIT;
          end else begin
            state <= S_IDLE;
          end
        end
        S_RD: begin
          // One-shot status read; device returns to prior state after
          FL_CE_N <= 1'b0;
          FL_OE_N <= 1'b0;
          ph <= ph + 4'h1;
          if (ph == `FPSC_WR_CYCLES) begin
            STATUS <= FL_DQ_IN;
            STATUS_VALID <= 1'b1;
            FL_CE_N <= 1'b1;
            FL_OE_N <= 1'b1;
            ph <= 4'h0;
            state <= S_IDLE;
          end
        end
        S_WAIT: begin
          lat <= lat - 16'h0001;
          if (lat == 16'h0001) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // Completion returns the device to read by itself; no reset issued
endmodule

// ==== dv/fpsc_host_monitor.sv ====
// ==========================================================
// Port checks of the command host
module fpsc_host_monitor (
  input wire CORE_CLK,
  input wire ARST_N,
  input wire CMD_VALID,
  input wire [2:0] CMD_OP,
  input wire [15:0] CMD_DATA,
  input wire [8:0] CMD_COUNT,
  input wire CMD_READY,
  input wire CMD_ERROR,
  input wire [23:0] FL_A,
  input wire [15:0] FL_DQ_OUT,
  input wire FL_DQ_OE,
  input wire FL_CE_N,
  input wire FL_WE_N,
  input wire FL_OE_N
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  wire take = CMD_VALID && CMD_READY;
  wire [7:0] d = FL_DQ_OUT[7:0];
  reg enh;
  always @(posedge CORE_CLK) if (take) enh <= CMD_DATA[0];
  property p_cnt;
    take && CMD_OP == 3'h1 && (CMD_COUNT == 9'h000 || CMD_COUNT > 9'h100)
      |-> ##[1:2] CMD_ERROR;
  endproperty
  a_cnt: assert property (p_cnt) else $error("bad count taken");
  property p_susp;
    take && CMD_OP == 3'h3 |-> ##[1:2] (CMD_ERROR ||
      (!FL_WE_N && d == (enh ? 8'h51 : 8'hB0)));
  endproperty
  a_susp: assert property (p_susp) else $error("bad suspend");
  property p_res;
    take && CMD_OP == 3'h4 |-> ##[1:2] (CMD_ERROR ||
      (!FL_WE_N && d == (enh ? 8'h50 : 8'h30)));
  endproperty
  a_res: assert property (p_res) else $error("bad resume");
  property p_stat;
    take && CMD_OP == 3'h5 |-> ##[1:2] (CMD_ERROR ||
      (!FL_WE_N && d == 8'h70 && FL_A[11:0] == 12'h555));
  endproperty
  a_stat: assert property (p_stat) else $error("bad status write");
  property p_err;
    CMD_ERROR |-> CMD_READY ##1 !CMD_ERROR;
  endproperty
  a_err: assert property (p_err) else $error("refusal changed state");
  property p_wr;
    $fell(FL_WE_N) |=> (!FL_CE_N && FL_DQ_OE && FL_OE_N &&
      $stable(FL_A) && $stable(FL_DQ_OUT))[*2];
  endproperty
  a_wr: assert property (p_wr) else $error("write cycle unstable");
  c_open: cover property (take && CMD_OP == 3'h1);
  c_susp: cover property (take && CMD_OP == 3'h3);
  c_stat: cover property (take && CMD_OP == 3'h5);
endmodule
bind fpsc_host fpsc_host_monitor u_mon (.CORE_CLK(CORE_CLK),
  .ARST_N(ARST_N), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
  .CMD_DATA(CMD_DATA), .CMD_COUNT(CMD_COUNT), .CMD_READY(CMD_READY),
  .CMD_ERROR(CMD_ERROR), .FL_A(FL_A), .FL_DQ_OUT(FL_DQ_OUT),
  .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N),
  .FL_OE_N(FL_OE_N));

// ==== dv/fpsc_flash_model.sv ====
// ==========================================================
// Behavioural flash, erase already held
module fpsc_flash_model #(parameter int LAT_NS = 10000,
  parameter int ESL_NS = 50, parameter int PROG_NS = 2000) (
  input wire [23:0] a,
  input wire [15:0] dq,
  input wire ce_n,
  input wire we_n,
  input wire oe_n,
  output logic [15:0] q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] st = 3'h0;
  logic [8:0] left = 9'h000;
  logic [7:0] sec = 8'h00;
  logic [7:0] last = 8'h00;
  logic conf_ok = 1'b0;
  logic [2:0] prev = 3'h0;
  int gen = 0;
  int fin = -1;
  logic erase_held = 1'b0;
  // Comes up with erase hold pending, settles within its latency
  initial erase_held <= #(ESL_NS) 1'b1;
  // Back in array read once a busy program has run to its end
  wire at_read = (st == 3'h0) || (st == 3'h4 && fin == gen);
  wire [15:0] stat = {13'h0000, st} | 16'h0080;
  // Released bus shows the inverse, never a stale value
  assign q = (!ce_n && !oe_n) ? stat : ~stat;
  always @(posedge we_n) if (!ce_n && erase_held) begin
    // Finished program has already dropped back to array read
    if (st == 3'h4 && fin == gen) st = 3'h0;
    prev = st;
    last = dq[7:0];
    // Unlock and status writes keep the state
    if (a[11:0] == 12'h555 || a[11:0] == 12'h2AA) begin
    end else case (st)
      3'h0: if (last == 8'h25) begin
        st = 3'h1;
        sec = a[23:16];
      end
      3'h1: begin
        left = dq[8:0] + 9'h001;
        st = (dq[8:0] > 9'h0FF) ? 3'h4 : 3'h2;
      end
      3'h2: begin
        left = left - 9'h001;
        if (a[23:16] != sec) st = 3'h4;
        else if (left == 9'h000) st = 3'h3;
      end
      3'h3: begin
        conf_ok = last == 8'h29 && a[23:16] == sec;
        st = 3'h4;
      end
      3'h4: if (last == 8'hB0 || last == 8'h51) begin
        st = 3'h5;
        st <= #(LAT_NS) 3'h6;
      end
      3'h6: if (last == 8'h30 || last == 8'h50) st = 3'h4;
      default: ; // Anything else is ignored
    endcase
    // Each entry into busy programming starts a fresh completion timer
    if (st == 3'h4 && prev != 3'h4) begin
      gen = gen + 1;
      fin <= #(PROG_NS) gen;
    end
  end
endmodule

// ==== dv/test_fpsc_host.sv ====
module test_fpsc_host;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, arst_n = 1'b0, valid = 1'b0, rdy, err, sv;
  logic oe, ce_n, we_n, oe_n, got_err;
  logic [2:0] op = 3'h0;
  logic [23:0] addr = 24'h000000, fa;
  logic [15:0] data = 16'h0000, stat, dqo, dqi;
  logic [8:0] cnt = 9'h000;
  int failures = 0, check_count = 0, cyc = 0, sv_count = 0;
  always #12.5 core_clk = ~core_clk;
  // Counts status pulses; a pulse standing two cycles counts twice
  always @(negedge core_clk) if (sv === 1'b1) sv_count++;
  fpsc_host u_dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .CMD_VALID(valid),
    .CMD_OP(op), .CMD_ADDR(addr), .CMD_DATA(data), .CMD_COUNT(cnt),
    .CMD_LAST(1'b0), .CMD_IN_ERASE_HOLD(1'b1), .CMD_READY(rdy),
    .CMD_ERROR(err), .STATUS(stat), .STATUS_VALID(sv), .FL_A(fa),
    .FL_DQ_OUT(dqo), .FL_DQ_OE(oe), .FL_DQ_IN(dqi), .FL_CE_N(ce_n),
    .FL_WE_N(we_n), .FL_OE_N(oe_n));
  fpsc_flash_model u_fl (.a(fa), .dq(oe ? dqo : dqi), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .q(dqi));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Held until taken, then wait for idle again
  task automatic cmd(input logic [2:0] o, input logic [23:0] a,
    input logic [15:0] d);
    @(posedge core_clk);
    op <= o;
    addr <= a;
    data <= d;
    cnt <= d[8:0];
    valid <= 1'b1;
    @(negedge core_clk);
    while (rdy !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    valid <= 1'b0;
    @(negedge core_clk);
    got_err = err;
    while (rdy !== 1'b1) @(negedge core_clk);
  endtask
  task automatic t_refuse;
    cmd(3'h1, 24'h120000, 16'h0000);
    chk(got_err, 1'b1);
    cmd(3'h1, 24'h120000, 16'h0101);
    chk(got_err, 1'b1);
    cmd(3'h4, 24'h000000, 16'h0000);
    chk(got_err, 1'b1);
    cmd(3'h2, 24'h120000, 16'h0000);
    chk(got_err, 1'b1);
  endtask
  task automatic t_buffer;
    cmd(3'h1, 24'h120000, 16'h0100);
    chk(u_fl.st, 3'h2);
    for (int i = 0; i < 256; i++) begin
      if (i == 5) begin
        cmd(3'h2, 24'h130000, 16'h0000);
        chk(got_err, 1'b1);
      end
      cmd(3'h2, {16'h1200, i[7:0]}, {8'h5A, i[7:0]});
    end
    chk(u_fl.st, 3'h4);
    chk(u_fl.conf_ok, 1'b1);
  endtask
  task automatic t_suspend;
    for (int m = 0; m < 2; m++) begin
      cmd(3'h3, 24'h000000, {15'h0000, m[0]});
      chk(u_fl.st, 3'h6);
      chk(u_fl.last, m[0] ? 8'h51 : 8'hB0);
      cmd(3'h3, 24'h000000, 16'h0000);
      chk(got_err, 1'b1);
      cmd(3'h5, 24'h000555, 16'h0000);
      chk(stat, 16'h0086);
      chk(16'(sv_count), 16'(m + 1));
      cmd(3'h6, 24'h000000, 16'h0000);
      chk(u_fl.st, 3'h6);
      cmd(3'h4, 24'h000000, {15'h0000, m[0]});
      chk(u_fl.last, m[0] ? 8'h50 : 8'h30);
      chk(u_fl.st, 3'h4);
    end
    repeat (100) @(posedge core_clk);
    chk(u_fl.at_read, 1'b1);
  endtask
  task automatic results;
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the ~4000 cycles the tests need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk(u_fl.erase_held, 1'b1);
    t_refuse();
    t_buffer();
    t_suspend();
    results();
  end
endmodule
